/* File: swts_pkg.sv */
// Purpose: shared constants, types and the check-byte function for the
//          single-wire temperature sensor slave.
// Assumes: 50 MHz system clock.
// Notes:   slot timing figures are in ns; cycle counts are derived.
package swts_pkg;

  // ------------------------------------------------------------
  // clock and line timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_RST_DET_NS = 120000;
  localparam int unsigned T_PRES_WAIT_NS = 30000;
  localparam int unsigned T_PRES_LOW_NS = 120000;
  localparam int unsigned T_SLOT_SAMPLE_NS = 30000;
  // least times round up
  localparam int unsigned RST_DET_CYC =
    (T_RST_DET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRES_WAIT_CYC =
    (T_PRES_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRES_LOW_CYC =
    (T_PRES_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLOT_SAMPLE_CYC =
    (T_SLOT_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [15:0] PRES_WAIT_LAST = 16'(PRES_WAIT_CYC - 1);
  localparam logic [15:0] SLOT_SAMPLE_LAST = 16'(SLOT_SAMPLE_CYC - 1);

  // ------------------------------------------------------------
  // identity-level and memory command codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_ID_READ = 8'h33;
  localparam logic [7:0] CMD_ID_MATCH = 8'h55;
  localparam logic [7:0] CMD_ID_SKIP = 8'hCC;
  localparam logic [7:0] CMD_ID_SEARCH = 8'hF0;
  localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_SPAD_READ = 8'hBE;
  localparam logic [7:0] CMD_SPAD_WRITE = 8'h4E;
  localparam logic [7:0] CMD_SPAD_COPY = 8'h48;
  localparam logic [7:0] CMD_RECALL = 8'hB8;

  // ------------------------------------------------------------
  // scratchpad layout, reset values, check polynomial
  // ------------------------------------------------------------
  localparam int unsigned SPAD_TEMP_LOW = 0;
  localparam int unsigned SPAD_TEMP_HIGH = 1;
  localparam int unsigned SPAD_HIGH_TRIG = 2;
  localparam int unsigned SPAD_LOW_TRIG = 3;
  localparam int unsigned SPAD_UNUSED_A = 4;
  localparam int unsigned SPAD_UNUSED_B = 5;
  localparam int unsigned SPAD_RESIDUAL = 6;
  localparam int unsigned SPAD_PER_DEG = 7;
  localparam logic [7:0] SPAD_UNUSED_VAL = 8'hFF;
  localparam logic [7:0] CHECK_POLY_REFL = 8'h8C;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] HIGH_TRIG_RESET = 8'h7F;
  localparam logic [7:0] LOW_TRIG_RESET = 8'h80;
  localparam logic [6:0] ID_LAST_BIT = 7'd63;
  localparam logic [6:0] SPAD_LAST_BIT = 7'd71;
  localparam logic [6:0] WR_LAST_BIT = 7'd15;
  localparam logic [6:0] BYTE_LAST_BIT = 7'd7;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RST_LOW = 4'b0001,
    ST_PRES_WAIT = 4'b0010,
    ST_PRES_LOW = 4'b0011,
    ST_ID_CMD = 4'b0100,
    ST_ID_READ = 4'b0101,
    ST_ID_MATCH = 4'b0110,
    ST_SEARCH = 4'b0111,
    ST_FN_CMD = 4'b1000,
    ST_SPAD_READ = 4'b1001,
    ST_SPAD_WRITE = 4'b1010,
    ST_DONE = 4'b1011
  } swts_state_e;

  typedef struct packed {
    logic valid;
    logic [15:0] temp;
    logic [7:0] residual;
    logic [7:0] per_deg;
  } swts_meas_s;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic line_prev;
    logic [15:0] low_cnt;
    logic [15:0] cnt;
    logic slot_act;
    logic drive;
    swts_state_e state;
    logic [6:0] bit_idx;
    logic [1:0] phase;
    logic [7:0] cmd_sh;
    logic [15:0] wr_sh;
    logic [7:0] crc;
    logic [15:0] temp;
    logic [7:0] high_trig;
    logic [7:0] low_trig;
    logic [7:0] nv_high;
    logic [7:0] nv_low;
    logic [7:0] residual;
    logic [7:0] per_deg;
    logic alarm;
    logic conv_start;
  } swts_regs_s;

  // one shift of the check register, data bit lsb first
  function automatic logic [7:0] swts_crc_step(input logic [7:0] crc,
                                               input logic din);
    logic fb;
    fb = crc[0] ^ din;
    swts_crc_step = {1'b0, crc[7:1]} ^ (fb ? CHECK_POLY_REFL : 8'h00);
  endfunction

  function automatic logic [7:0] swts_crc56(input logic [55:0] data);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = swts_crc_step(c, data[i]);
    end
    swts_crc56 = c;
  endfunction

endpackage

/* File: swts_slave.sv */
// Purpose: slave end of a single-contact bus for a digital thermometer:
//          identity, search, scratchpad, check byte and alarm flag.
// Assumes: measurement core outside; result arrives as meas_in pulse.
// Notes:   one clock; the line is sampled through two flops.
`timescale 1ns/1ps
module swts_slave
  import swts_pkg::*;
#(
  parameter logic [7:0] FAMILY_CODE = 8'h3C, // arbitrary value
  parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001, // arbitrary
  parameter int unsigned RST_LOW_CYC = RST_DET_CYC,
  parameter int unsigned PRES_DRIVE_CYC = PRES_LOW_CYC,
  parameter int unsigned SLOT_CYC = SLOT_SAMPLE_CYC
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_out,
  input wire swts_meas_s meas_in,
  output logic conv_start_out,
  output logic alarm_out
);

  // ------------------------------------------------------------
  // identity and timing constants
  // ------------------------------------------------------------
  // identity layout
  localparam logic [63:0] ID_CODE = {swts_crc56({SERIAL_NUMBER, FAMILY_CODE}),
                                     SERIAL_NUMBER, FAMILY_CODE};
  localparam logic [15:0] RST_LOW_LAST = 16'(RST_LOW_CYC - 1);
  localparam logic [15:0] PRES_LOW_LAST = 16'(PRES_DRIVE_CYC - 1);
  // slot sample point; shortened only to keep long runs affordable
  localparam logic [15:0] SLOT_LAST = 16'(SLOT_CYC - 1);

  swts_regs_s r_ff;
  swts_regs_s nxt_r;
  logic line;
  logic fall;
  logic tx_en;
  logic tx_bit;
  logic rx_bit;
  logic bit_done;
  logic [63:0] spad;
  logic [7:0] cmd_byte;
  logic [15:0] wr_word;
  logic id_bit;
  logic signed [7:0] whole_deg;

  assign line = r_ff.sync2;
  assign fall = r_ff.line_prev & ~r_ff.sync2;
  assign rx_bit = r_ff.sync2;
  assign id_bit = ID_CODE[r_ff.bit_idx[5:0]];
  assign bit_done = r_ff.slot_act && (r_ff.cnt == SLOT_LAST);
  assign cmd_byte = {rx_bit, r_ff.cmd_sh[7:1]};
  assign wr_word = {rx_bit, r_ff.wr_sh[15:1]};
  // drop the half-degree bit; bit 8 is the sign
  assign whole_deg = signed'(meas_in.temp[8:1]);

  // scratchpad image, unused bytes read ones
  always_comb begin
    spad = 64'h0000_0000_0000_0000;
    spad[SPAD_TEMP_LOW*8 +: 8] = r_ff.temp[7:0];
    spad[SPAD_TEMP_HIGH*8 +: 8] = r_ff.temp[15:8];
    spad[SPAD_HIGH_TRIG*8 +: 8] = r_ff.high_trig;
    spad[SPAD_LOW_TRIG*8 +: 8] = r_ff.low_trig;
    spad[SPAD_UNUSED_A*8 +: 8] = SPAD_UNUSED_VAL;
    spad[SPAD_UNUSED_B*8 +: 8] = SPAD_UNUSED_VAL;
    spad[SPAD_RESIDUAL*8 +: 8] = r_ff.residual;
    spad[SPAD_PER_DEG*8 +: 8] = r_ff.per_deg;
  end

  // ------------------------------------------------------------
  // bit to send in the current slot
  // ------------------------------------------------------------
  always_comb begin
    tx_en = 1'b0;
    tx_bit = 1'b1;
    case (r_ff.state)
      ST_ID_READ: begin
        tx_en = 1'b1;
        tx_bit = id_bit;
      end
      ST_SEARCH: begin
        tx_en = (r_ff.phase != 2'd2);
        tx_bit = (r_ff.phase == 2'd0) ? id_bit : ~id_bit;
      end
      ST_SPAD_READ: begin
        // check byte falls out of the register lsb first
        tx_en = 1'b1;
        tx_bit = (r_ff.bit_idx < 7'd64) ? spad[r_ff.bit_idx[5:0]]
                                        : r_ff.crc[0];
      end
      default: begin
        tx_en = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;
    nxt_r.sync1 = dq_in;
    nxt_r.sync2 = r_ff.sync1;
    nxt_r.line_prev = r_ff.sync2;
    nxt_r.conv_start = 1'b0;

    // re-judge alarm on stored triggers each reading
    if (meas_in.valid) begin
      nxt_r.temp = meas_in.temp;
      nxt_r.residual = meas_in.residual;
      nxt_r.per_deg = meas_in.per_deg;
      nxt_r.alarm = (whole_deg > signed'(r_ff.nv_high)) ||
                    (whole_deg < signed'(r_ff.nv_low));
    end

    // low time counted only while the line is not ours
    if (!line && !r_ff.drive) begin
      if (r_ff.low_cnt != 16'hFFFF) begin
        nxt_r.low_cnt = r_ff.low_cnt + 16'd1;
      end
    end else if (line) begin
      nxt_r.low_cnt = 16'h0000;
    end

    // slot timer runs from the master's falling edge
    if (r_ff.slot_act) begin
      nxt_r.cnt = r_ff.cnt + 16'd1;
    end
    if (bit_done) begin
      nxt_r.slot_act = 1'b0;
      nxt_r.drive = 1'b0;
      nxt_r.bit_idx = r_ff.bit_idx + 7'd1;
    end

    case (r_ff.state)
      ST_IDLE, ST_DONE: begin
        // dropped devices wait here for a reset
      end
      ST_RST_LOW: begin
        // release of reset pulse starts presence delay
        if (line) begin
          nxt_r.state = ST_PRES_WAIT;
          nxt_r.cnt = 16'h0000;
        end
      end
      ST_PRES_WAIT: begin
        nxt_r.cnt = r_ff.cnt + 16'd1;
        if (r_ff.cnt == PRES_WAIT_LAST) begin
          nxt_r.state = ST_PRES_LOW;
          nxt_r.cnt = 16'h0000;
          nxt_r.drive = 1'b1;
        end
      end
      ST_PRES_LOW: begin
        nxt_r.cnt = r_ff.cnt + 16'd1;
        if (r_ff.cnt == PRES_LOW_LAST) begin
          nxt_r.drive = 1'b0;
          nxt_r.state = ST_ID_CMD;
          nxt_r.bit_idx = 7'd0;
          nxt_r.slot_act = 1'b0;
        end
      end
      ST_ID_CMD: begin
        if (bit_done) begin
          nxt_r.cmd_sh = cmd_byte;
          if (r_ff.bit_idx == BYTE_LAST_BIT) begin
            nxt_r.bit_idx = 7'd0;
            nxt_r.phase = 2'd0;
            case (cmd_byte)
              CMD_ID_READ: nxt_r.state = ST_ID_READ;
              CMD_ID_MATCH: nxt_r.state = ST_ID_MATCH;
              CMD_ID_SKIP: nxt_r.state = ST_FN_CMD;
              CMD_ID_SEARCH: nxt_r.state = ST_SEARCH;
              // silent for alarm search unless alarming
              CMD_ALARM_SEARCH: begin
                nxt_r.state = r_ff.alarm ? ST_SEARCH : ST_DONE;
              end
              default: nxt_r.state = ST_DONE;
            endcase
          end
        end
      end
      ST_ID_READ: begin
        // memory command only after full identity
        if (bit_done && r_ff.bit_idx == ID_LAST_BIT) begin
          nxt_r.state = ST_FN_CMD;
          nxt_r.bit_idx = 7'd0;
        end
      end
      ST_ID_MATCH: begin
        if (bit_done) begin
          // any differing bit drops the device
          if (rx_bit != id_bit) begin
            nxt_r.state = ST_DONE;
          end else if (r_ff.bit_idx == ID_LAST_BIT) begin
            nxt_r.state = ST_FN_CMD;
            nxt_r.bit_idx = 7'd0;
          end
        end
      end
      ST_SEARCH: begin
        if (bit_done) begin
          if (r_ff.phase != 2'd2) begin
            // index advances only after the master's bit
            nxt_r.bit_idx = r_ff.bit_idx;
            nxt_r.phase = r_ff.phase + 2'd1;
          end else begin
            nxt_r.phase = 2'd0;
            // drop out on a differing direction bit
            if (rx_bit != id_bit) begin
              nxt_r.state = ST_DONE;
            end else if (r_ff.bit_idx == ID_LAST_BIT) begin
              nxt_r.state = ST_FN_CMD;
              nxt_r.bit_idx = 7'd0;
            end
          end
        end
      end
      ST_FN_CMD: begin
        // memory commands reachable only from here
        if (bit_done) begin
          nxt_r.cmd_sh = cmd_byte;
          if (r_ff.bit_idx == BYTE_LAST_BIT) begin
            nxt_r.bit_idx = 7'd0;
            nxt_r.state = ST_DONE;
            case (cmd_byte)
              CMD_CONVERT: nxt_r.conv_start = 1'b1;
              CMD_SPAD_READ: begin
                nxt_r.state = ST_SPAD_READ;
                nxt_r.crc = 8'h00;
              end
              CMD_SPAD_WRITE: nxt_r.state = ST_SPAD_WRITE;
              CMD_SPAD_COPY: begin
                nxt_r.nv_high = r_ff.high_trig;
                nxt_r.nv_low = r_ff.low_trig;
              end
              CMD_RECALL: begin
                nxt_r.high_trig = r_ff.nv_high;
                nxt_r.low_trig = r_ff.nv_low;
              end
              default: nxt_r.state = ST_DONE;
            endcase
          end
        end
      end
      ST_SPAD_READ: begin
        if (bit_done) begin
          // every sent bit shifts the check register
          nxt_r.crc = swts_crc_step(r_ff.crc, tx_bit);
          // ends after the check byte or at any reset
          if (r_ff.bit_idx == SPAD_LAST_BIT) begin
            nxt_r.state = ST_DONE;
          end
        end
      end
      ST_SPAD_WRITE: begin
        if (bit_done) begin
          nxt_r.wr_sh = wr_word;
          if (r_ff.bit_idx == WR_LAST_BIT) begin
            nxt_r.high_trig = wr_word[7:0];
            nxt_r.low_trig = wr_word[15:8];
            nxt_r.state = ST_DONE;
          end
        end
      end
      default: nxt_r.state = ST_IDLE;
    endcase

    // start of a slot; no state ever waits on a check result
    if (fall && !r_ff.slot_act && (r_ff.state >= ST_ID_CMD)) begin
      nxt_r.slot_act = 1'b1;
      nxt_r.cnt = 16'h0000;
      // only ever pull low for a zero
      nxt_r.drive = tx_en & ~tx_bit;
    end

    // long low wins over everything else
    if (r_ff.low_cnt >= RST_LOW_LAST && !line) begin
      nxt_r.state = ST_RST_LOW;
      nxt_r.slot_act = 1'b0;
      nxt_r.drive = 1'b0;
      nxt_r.bit_idx = 7'd0;
      nxt_r.phase = 2'd0;
      nxt_r.cmd_sh = 8'h00;
    end
  end

  // ------------------------------------------------------------
  // state register; reset also stands for power-on recall
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      r_ff <= '0;
      r_ff.sync1 <= 1'b1;
      r_ff.sync2 <= 1'b1;
      r_ff.line_prev <= 1'b1;
      r_ff.state <= ST_IDLE;
      r_ff.temp <= TEMP_RESET;
      r_ff.residual <= COUNT_RESET;
      r_ff.per_deg <= COUNT_RESET;
      r_ff.nv_high <= HIGH_TRIG_RESET;
      r_ff.nv_low <= LOW_TRIG_RESET;
      r_ff.high_trig <= HIGH_TRIG_RESET;
      r_ff.low_trig <= LOW_TRIG_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // open-drain: data is always low, enable pulls
  assign dq_out = 1'b0;
  assign dq_oe_out = r_ff.drive;
  assign conv_start_out = r_ff.conv_start;
  assign alarm_out = r_ff.alarm;

endmodule

/* File: swts_slave_properties.sv */
// Purpose: port-level checks on the single-wire sensor slave.
// Assumes: dq_in is the resolved line, low whenever dq_oe_out is high.
// Notes: counters stand in for the long waits of the line protocol.
`timescale 1ns/1ps
module swts_slave_properties
  import swts_pkg::*;
#(
  parameter int unsigned RST_LOW_CYC = RST_DET_CYC,
  parameter int unsigned PRES_DRIVE_CYC = PRES_LOW_CYC,
  parameter int unsigned SLOT_CYC = SLOT_SAMPLE_CYC
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_out,
  input wire swts_meas_s meas_in,
  input wire logic conv_start_out,
  input wire logic alarm_out
);
  localparam int unsigned MAX_HI = PRES_DRIVE_CYC + SLOT_CYC;
  localparam int unsigned MIN_HI =
    (PRES_DRIVE_CYC < SLOT_CYC ? PRES_DRIVE_CYC : SLOT_CYC) - 8;
  logic [15:0] lo_cnt_ff;
  logic [15:0] hi_cnt_ff;
  logic [15:0] since_rst_ff;
  logic line_prev_ff;
  logic pres_seen_ff;
  logic rst_end;

  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  // own drive never counts as master low time
  assign rst_end = dq_in && !line_prev_ff && lo_cnt_ff >= 16'(RST_LOW_CYC);
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      lo_cnt_ff <= 16'h0000;
      hi_cnt_ff <= 16'h0000;
      since_rst_ff <= 16'hFFFF;
      line_prev_ff <= 1'b1;
      pres_seen_ff <= 1'b0;
    end else begin
      // presence window too long for a delay range; count it instead
      if (rst_end)
        pres_seen_ff <= 1'b0;
      else if (dq_oe_out)
        pres_seen_ff <= 1'b1;
      lo_cnt_ff <= (dq_in || dq_oe_out) ? 16'h0000 : lo_cnt_ff + 16'h0001;
      hi_cnt_ff <= dq_oe_out ? hi_cnt_ff + 16'h0001 : 16'h0000;
      if (rst_end)
        since_rst_ff <= 16'h0000;
      else if (since_rst_ff != 16'hFFFF)
        since_rst_ff <= since_rst_ff + 16'h0001;
      line_prev_ff <= dq_in;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  drain_only_a: assert property (dq_out == 1'b0)
    else $error("data output not held low");
  line_pulled_a: assert property (dq_oe_out |-> !dq_in)
    else $error("line high while pulled");
  quiet_release_a: assert property ($fell(reset_in) |->
    !dq_oe_out && !alarm_out && !conv_start_out)
    else $error("outputs active after reset");
  alarm_hold_a: assert property (!meas_in.valid |=> $stable(alarm_out))
    else $error("alarm changed without reading");
  presence_due_a: assert property (since_rst_ff == 16'd3000 |->
    pres_seen_ff)
    else $error("presence pulse missing");
  presence_early_a: assert property ($rose(dq_oe_out) |->
    since_rst_ff >= 16'd750)
    else $error("presence pulse too early");
  drive_bounded_a: assert property (hi_cnt_ff <= 16'(MAX_HI))
    else $error("line held too long");
  drive_min_a: assert property ($fell(dq_oe_out) |->
    hi_cnt_ff >= 16'(MIN_HI))
    else $error("line drive too short");
  reset_silent_a: assert property (lo_cnt_ff >= 16'(RST_LOW_CYC)
    && !dq_in |=> !dq_oe_out)
    else $error("drive during bus reset");

  cover property (since_rst_ff == 16'd3000 && pres_seen_ff);
  cover property ($rose(alarm_out));
  cover property ($fell(dq_oe_out) && hi_cnt_ff == 16'(SLOT_CYC));
endmodule

bind swts_slave swts_slave_properties #(
  .RST_LOW_CYC(RST_LOW_CYC),
  .PRES_DRIVE_CYC(PRES_DRIVE_CYC),
  .SLOT_CYC(SLOT_CYC)
) props (
  .clk_in(clk_in),
  .reset_in(reset_in),
  .dq_in(dq_in),
  .dq_out(dq_out),
  .dq_oe_out(dq_oe_out),
  .meas_in(meas_in),
  .conv_start_out(conv_start_out),
  .alarm_out(alarm_out)
);

/* File: swts_bus_master_model.sv */
// Purpose: bus master on the far side of the single-wire sensor slave.
// Assumes: pull_out high pulls the line low; a pull-up idles it high.
// Notes: times in cycles at 50 MHz; reads sampled at half the slave slot.
`timescale 1ns/1ps
module swts_bus_master_model
  import swts_pkg::*;
#(
  parameter int unsigned RST_HOLD = 2500,
  parameter int unsigned SLOT_CYC = SLOT_SAMPLE_CYC
) (
  input wire logic clk_in,
  input wire logic line_in,
  output logic pull_out
);
  int unsigned pres_wait;
  int unsigned pres_len;

  initial pull_out = 1'b0;

  task automatic bus_reset();
    @(posedge clk_in);
    pull_out <= 1'b1;
    repeat (RST_HOLD) @(posedge clk_in);
    pull_out <= 1'b0;
    pres_wait = 0;
    pres_len = 0;
    do begin
      @(posedge clk_in);
      pres_wait++;
    end while (line_in !== 1'b0 && pres_wait < 4000);
    while (line_in === 1'b0 && pres_len < 4000) begin
      @(posedge clk_in);
      pres_len++;
    end
    repeat (200) @(posedge clk_in);
  endtask

  // one slot; a read is a write of one
  task automatic slot(input logic wbit, output logic rbit);
    @(posedge clk_in);
    pull_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    pull_out <= !wbit;
    repeat (SLOT_CYC / 2 - 5) @(posedge clk_in);
    rbit = line_in;
    // write-zero held past the slave's sample point
    repeat (SLOT_CYC / 2 + 15) @(posedge clk_in);
    pull_out <= 1'b0;
    repeat (20) @(posedge clk_in);
  endtask

  task automatic write_byte(input logic [7:0] val);
    logic r;
    for (int i = 0; i < 8; i++) slot(val[i], r);
  endtask

  task automatic read_byte(output logic [7:0] val);
    for (int i = 0; i < 8; i++) slot(1'b1, val[i]);
  endtask
endmodule

/* File: tb_single_wire_temp_sensor_slave.sv */
// Purpose: self-checking bench for the single-wire sensor slave.
// Assumes: open-drain line, pull-up, master model on the far side.
// Notes: bus reset threshold and presence shortened by parameters.
`timescale 1ns/1ps
module tb_single_wire_temp_sensor_slave;
  import swts_pkg::*;
  localparam logic [7:0] FAM = 8'h5A; // arbitrary value
  localparam logic [47:0] SER = 48'h0000_1234_5678; // arbitrary value
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  swts_meas_s meas_in = '0;
  logic dq_out;
  logic dq_oe_out;
  logic conv_start_out;
  logic alarm_out;
  logic pull;
  logic line;
  logic [7:0] b8;
  logic [7:0] spad [8];
  logic [15:0] temp;
  logic [7:0] crc;
  logic [7:0] id_chk;
  int conv_count = 0;
  int err_count = 0;
  int comparisons = 0;
  int seed = 32'hc524_b039;
  int th;
  int tl;
  int t9;
  int whole;
  bit alarm_exp;

  always #10 clk_in = ~clk_in;
  assign line = !(pull || dq_oe_out);

  // threshold above a write-zero slot, or slots would reset the slave;
  // short slots keep the whole run affordable
  swts_slave #(
    .FAMILY_CODE(FAM),
    .SERIAL_NUMBER(SER),
    .RST_LOW_CYC(2000),
    .PRES_DRIVE_CYC(100),
    .SLOT_CYC(60)
  ) dut (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .dq_in(line),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out),
    .meas_in(meas_in),
    .conv_start_out(conv_start_out),
    .alarm_out(alarm_out)
  );

  swts_bus_master_model #(
    .SLOT_CYC(60)
  ) m (
    .clk_in(clk_in),
    .line_in(line),
    .pull_out(pull)
  );

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // convert pulses counted as they pass
  always @(posedge clk_in) begin
    if (conv_start_out === 1'b1)
      conv_count <= conv_count + 1;
  end

  // reference check register, lsb first
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? CHECK_POLY_REFL : 8'h00);
    return c;
  endfunction

  task automatic conclude();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic init();
    m.bus_reset();
    check("presence wait", 16'h1, 16'(m.pres_wait >= 750 && m.pres_wait <= 3000));
    check("presence length", 16'h1, 16'(m.pres_len >= 98 && m.pres_len <= 102));
    if (m.pres_wait >= 4000 || m.pres_len >= 4000)
      conclude();
  endtask

  task automatic skip_to(input logic [7:0] fn);
    init();
    m.write_byte(CMD_ID_SKIP);
    m.write_byte(fn);
  endtask

  task automatic search(input logic armed);
    logic b;
    logic c;
    init();
    m.write_byte(CMD_ALARM_SEARCH);
    m.slot(1'b1, b);
    m.slot(1'b1, c);
    check("search bit", armed ? 16'(FAM[0]) : 16'h1, 16'(b));
    check("search complement", armed ? 16'(!FAM[0]) : 16'h1, 16'(c));
    if (armed) begin
      m.slot(!FAM[0], b);
      m.slot(1'b1, b);
      m.slot(1'b1, c);
      check("dropped search", 16'h3, 16'({b, c}));
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    search(1'b0);
    $display("idle alarm search done");
    th = 10 + ($random(seed) & 31);
    tl = -1 - ($random(seed) & 31);
    skip_to(CMD_SPAD_WRITE);
    m.write_byte(8'(th));
    m.write_byte(8'(tl));
    skip_to(CMD_SPAD_COPY);
    $display("trigger write and copy done");
    check("convert pulses", 16'h0, 16'(conv_count));
    id_chk = crc_byte(8'h00, FAM);
    for (int i = 0; i < 6; i++)
      id_chk = crc_byte(id_chk, SER[8*i +: 8]);
    init();
    m.write_byte(CMD_ID_READ);
    crc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m.read_byte(b8);
      crc = crc_byte(crc, b8);
      if (i == 0)
        check("family code", 16'(FAM), 16'(b8));
      else if (i < 7)
        check("serial byte", 16'(SER[8*i-8 +: 8]), 16'(b8));
      else
        check("identity check byte", 16'(id_chk), 16'(b8));
    end
    check("identity residue", 16'h0, 16'(crc));
    m.write_byte(CMD_CONVERT);
    check("convert pulses", 16'h1, 16'(conv_count));
    $display("identity read and convert done");
    for (int i = 0; i < 24; i++) begin
      case (i)
        0: t9 = 2 * th + 1;
        1: t9 = 2 * th + 2;
        2: t9 = 2 * tl;
        3: t9 = 2 * tl - 1;
        23: t9 = 2 * tl - 4;
        default: t9 = ($random(seed) & 255) - 110;
      endcase
      temp = 16'(t9);
      whole = t9 >>> 1;
      alarm_exp = whole > th || whole < tl;
      meas_in <= '{valid: 1'b1, temp: temp, residual: 8'(i), per_deg: 8'h50};
      @(posedge clk_in);
      meas_in.valid <= 1'b0;
      repeat (3) @(posedge clk_in);
      check("alarm flag", 16'(alarm_exp), 16'(alarm_out));
    end
    $display("alarm compare done");
    skip_to(CMD_SPAD_READ);
    spad = '{temp[7:0], temp[15:8], 8'(th), 8'(tl), 8'hFF, 8'hFF, 8'h17,
             8'h50};
    crc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m.read_byte(b8);
      crc = crc_byte(crc, spad[i]);
      check("scratchpad byte", 16'(spad[i]), 16'(b8));
    end
    m.read_byte(b8);
    check("scratchpad check byte", 16'(crc), 16'(b8));
    $display("scratchpad read done");
    init();
    m.write_byte(CMD_ID_MATCH);
    m.write_byte(FAM);
    for (int i = 0; i < 6; i++)
      m.write_byte(SER[8*i +: 8]);
    m.write_byte(id_chk);
    m.write_byte(CMD_SPAD_READ);
    m.read_byte(b8);
    check("matched read", 16'(temp[7:0]), 16'(b8));
    $display("identity match done");
    search(1'b1);
    $display("armed alarm search done");
    conclude();
  end
endmodule
